// [rtl/touch_decision_pkg.sv]
// Purpose: Shared constants and types of the touch decision block
// Assumes: One clock at 10 MHz
// Notes: Register offsets are byte addresses of the register port
package touch_decision_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BTN_CFG = 8'h21;
	localparam logic [7:0] ADDR_BTN_AVG = 8'h22;
	localparam logic [7:0] ADDR_BTN_NEG_LVL = 8'h23;
	localparam logic [7:0] ADDR_BTN_NEG_LIM = 8'h24;
	localparam logic [7:0] ADDR_BTN_HYST = 8'h25;
	localparam logic [7:0] ADDR_BTN_HOLD = 8'h26;
	localparam logic [7:0] ADDR_WHL_CFG = 8'h27;
	localparam logic [7:0] ADDR_WHL_HOLD = 8'h28;
	localparam logic [7:0] ADDR_WHL_HYST = 8'h29;
	// ------------------------------------------------------------
	// Field positions and codes
	// ------------------------------------------------------------
	localparam int TOUCH_DEB_LSB = 0;
	localparam int REL_DEB_LSB = 2;
	localparam int IRQ_SEL_LSB = 4;
	localparam int MODE_LSB = 6;
	localparam logic [1:0] MODE_SINGLE = 2'h1;
	localparam logic [7:0] WHL_CFG_MASK = 8'h0f;
	localparam logic [23:0] PCT_FULL = 24'h00_0064;
	localparam int BTN_AVG_LIMIT = 3;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int HOLD_UNIT_MS = 1000;
	localparam int CLK_KHZ = 10000;
	localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_MS * CLK_KHZ;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] button_config;
		logic [7:0] button_average_limit;
		logic [7:0] button_negative_comp_level;
		logic [7:0] button_negative_count_limit;
		logic [7:0] button_hysteresis_pct;
		logic [7:0] button_hold_timeout;
		logic [7:0] wheel_debounce_config;
		logic [7:0] wheel_hold_timeout;
		logic [7:0] wheel_hysteresis_level;
	} regs_s;
	typedef struct packed {
		logic touched;
		logic stuck;
		logic [2:0] deb;
		logic [7:0] neg;
		logic [7:0] secs;
	} chan_s;
	typedef struct packed {
		chan_s c;
		logic touch;
		logic rel;
	} dec_s;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam regs_s REGS_RST = '{
		button_config: 8'h30,
		button_average_limit: 8'h50,
		button_negative_comp_level: 8'h50,
		button_negative_count_limit: 8'h01,
		button_hysteresis_pct: 8'h0a,
		button_hold_timeout: 8'h00,
		wheel_debounce_config: 8'h00,
		wheel_hold_timeout: 8'h00,
		wheel_hysteresis_level: 8'h03
	};
endpackage : touch_decision_pkg

// [rtl/touch_button_decision.sv]
// Purpose: Per-sensor touch and release decisions, wheel decision, compensation triggers
// Assumes: Samples, levels and pressure come from logic on clk; one sample per scan
// Notes: Registers reached by a plain byte-wide register port at their offsets
`timescale 1ns/1ps
module touch_button_decision #(
	parameter int N = 8,
	parameter int TW = 16,
	parameter int SEC_CYCLES = touch_decision_pkg::HOLD_UNIT_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic sample_valid,
	input wire logic [N-1:0][TW-1:0] ticks,
	input wire logic [N-1:0][TW-1:0] sensor_touch_level,
	input wire logic [TW-1:0] wheel_pressure,
	output logic [N-1:0] button_touched,
	output logic [N-1:0] avg_suspend,
	output logic touch_pulse,
	output logic release_pulse,
	output logic irq,
	output logic comp_req,
	output logic wheel_touched,
	output logic wheel_touch_pulse,
	output logic wheel_release_pulse
);
	localparam int IW = (N > 1) ? $clog2(N) : 1;
	localparam int SEC_W = $clog2(SEC_CYCLES + 1);

	typedef struct packed {
		touch_decision_pkg::regs_s regs;
		touch_decision_pkg::chan_s [N-1:0] btn;
		touch_decision_pkg::chan_s whl;
		logic owner_valid;
		logic [IW-1:0] owner;
		logic [N-1:0] avg_suspend;
		logic touch_pulse;
		logic rel_pulse;
		logic irq;
		logic comp_req;
		logic whl_touch_pulse;
		logic whl_rel_pulse;
		logic [7:0] rdata;
		logic [SEC_W-1:0] sec_cnt;
	} state_s;

	state_s st;
	state_s next_st;

	// ------------------------------------------------------------
	// Debounced decision shared by buttons and wheel
	// ------------------------------------------------------------
	function automatic touch_decision_pkg::dec_s decide(
		input touch_decision_pkg::chan_s c,
		input logic on,
		input logic off,
		input logic [1:0] ton,
		input logic [1:0] toff
	);
		touch_decision_pkg::dec_s d;
		d.c = c;
		d.touch = 1'b0;
		d.rel = 1'b0;
		if (c.stuck)
		begin
			// A forced release waits for the finger to really leave
			d.c.deb = 3'h0;
			if (off)
				d.c.stuck = 1'b0;
		end
		else if (!c.touched)
		begin
			if (on)
			begin
				if (c.deb >= {1'b0, ton})
				begin
					d.c.touched = 1'b1;
					d.c.deb = 3'h0;
					d.c.secs = 8'h00;
					d.touch = 1'b1;
				end
				else
					d.c.deb = c.deb + 3'h1;
			end
			else
				d.c.deb = 3'h0;
		end
		else
		begin
			if (off)
			begin
				if (c.deb >= {1'b0, toff})
				begin
					d.c.touched = 1'b0;
					d.c.deb = 3'h0;
					d.rel = 1'b1;
				end
				else
					d.c.deb = c.deb + 3'h1;
			end
			else
				d.c.deb = 3'h0;
		end
		return d;
	endfunction : decide

	// ------------------------------------------------------------
	// Hold timer, stepped by the one-second enable
	// ------------------------------------------------------------
	function automatic touch_decision_pkg::dec_s hold(
		input touch_decision_pkg::chan_s c,
		input logic [7:0] limit
	);
		touch_decision_pkg::dec_s d;
		d.c = c;
		d.touch = 1'b0;
		d.rel = 1'b0;
		if (c.touched && limit != 8'h00)
		begin
			d.c.secs = c.secs + 8'h01;
			if (d.c.secs >= limit)
			begin
				d.c.touched = 1'b0;
				d.c.stuck = 1'b1;
				d.c.deb = 3'h0;
				d.rel = 1'b1;
			end
		end
		return d;
	endfunction : hold

	logic sec_hit, single, busy, any_touch, any_rel, on, off, in_map;
	logic [IW:0] n_avg;
	logic [TW+7:0] prod;
	logic [TW-1:0] hyst, lower;
	logic [TW:0] upper;
	logic signed [TW+1:0] t_ext;
	logic [7:0] neg_lim;
	logic [3:0] slot;
	touch_decision_pkg::dec_s d;
	touch_decision_pkg::regs_s r;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		r = st.regs;
		sec_hit = (st.sec_cnt == SEC_W'(SEC_CYCLES - 1));
		single = (r.button_config[touch_decision_pkg::MODE_LSB +: 2]
			== touch_decision_pkg::MODE_SINGLE);
		busy = st.owner_valid & single;
		any_touch = 1'b0;
		any_rel = 1'b0;
		n_avg = '0;
		prod = '0;
		hyst = '0;
		upper = '0;
		lower = '0;
		t_ext = '0;
		on = 1'b0;
		off = 1'b0;
		neg_lim = 8'h00;
		d = '0;
		in_map = (reg_addr >= touch_decision_pkg::ADDR_BTN_CFG)
			&& (reg_addr <= touch_decision_pkg::ADDR_WHL_HYST);
		slot = 4'(touch_decision_pkg::ADDR_WHL_HYST - reg_addr);
		next_st.comp_req = 1'b0;
		next_st.sec_cnt = sec_hit ? '0 : st.sec_cnt + 1'b1;
		if (!single)
			next_st.owner_valid = 1'b0;

		// Register port; offsets are consecutive in struct order, so one index reaches all
		if (reg_wr && in_map)
			next_st.regs[8 * slot +: 8] = reg_wdata;
		if (reg_wr && reg_addr == touch_decision_pkg::ADDR_WHL_CFG)
			next_st.regs.wheel_debounce_config = reg_wdata & touch_decision_pkg::WHL_CFG_MASK;
		if (reg_rd && in_map)
			next_st.rdata = r[8 * slot +: 8];
		else if (reg_rd)
			next_st.rdata = 8'h00;

		// Limit zero is reserved; it acts as one
		neg_lim = (r.button_negative_count_limit == 8'h00) ? 8'h01
			: r.button_negative_count_limit;

		for (int i = 0; i < N; i++)
		begin
			d.c = st.btn[i];
			d.touch = 1'b0;
			d.rel = 1'b0;
			if (sample_valid)
			begin
				prod = sensor_touch_level[i] * r.button_hysteresis_pct;
				hyst = TW'(prod / touch_decision_pkg::PCT_FULL);
				upper = {1'b0, sensor_touch_level[i]} + {1'b0, hyst};
				// Percentages above 100 would wrap the release level
				lower = (hyst > sensor_touch_level[i]) ? '0
					: sensor_touch_level[i] - hyst;
				t_ext = {{2{ticks[i][TW-1]}}, ticks[i]};
				on = t_ext > $signed({1'b0, upper});
				off = t_ext < $signed({2'b00, lower});
				d = decide(st.btn[i], on, off,
					r.button_config[touch_decision_pkg::TOUCH_DEB_LSB +: 2],
					r.button_config[touch_decision_pkg::REL_DEB_LSB +: 2]);
				// Averaging limit counts in steps of four ticks
				next_st.avg_suspend[i] = t_ext
					>= $signed({8'h00, r.button_average_limit, 2'b00});
				if (t_ext + $signed({8'h00, r.button_negative_comp_level, 2'b00}) < 0)
				begin
					d.c.neg = (st.btn[i].neg == 8'hff) ? 8'hff
						: st.btn[i].neg + 8'h01;
					if (d.c.neg >= neg_lim)
					begin
						next_st.comp_req = 1'b1;
						d.c.neg = 8'h00;
					end
				end
				else
					d.c.neg = 8'h00;
			end
			else if (sec_hit)
				d = hold(st.btn[i], r.button_hold_timeout);
			if (single && busy && d.touch && next_st.owner != IW'(i))
			begin
				d.c.touched = 1'b0;
				d.touch = 1'b0;
			end
			else if (single && d.touch && !busy)
			begin
				busy = 1'b1;
				next_st.owner_valid = 1'b1;
				next_st.owner = IW'(i);
			end
			if (single && d.rel && st.owner_valid && st.owner == IW'(i))
			begin
				next_st.owner_valid = 1'b0;
				busy = 1'b0;
			end
			else if (single && d.rel)
				d.rel = 1'b0;
			next_st.btn[i] = d.c;
			any_touch = any_touch | d.touch;
			any_rel = any_rel | d.rel;
		end
		for (int i = 0; i < N; i++)
			n_avg = n_avg + (IW + 1)'(next_st.avg_suspend[i]);
		if (sample_valid && n_avg >= (IW + 1)'(touch_decision_pkg::BTN_AVG_LIMIT))
			next_st.comp_req = 1'b1;

		next_st.touch_pulse = any_touch;
		next_st.rel_pulse = any_rel;
		next_st.irq = (any_touch & r.button_config[touch_decision_pkg::IRQ_SEL_LSB])
			| (any_rel & r.button_config[touch_decision_pkg::IRQ_SEL_LSB + 1]);

		// Wheel decision on the pressure from the front end
		if (sample_valid)
		begin
			on = {8'h00, wheel_pressure}
				> {6'b00_0000, r.wheel_hysteresis_level, 2'b00};
			off = (wheel_pressure == '0);
			d = decide(st.whl, on, off,
				r.wheel_debounce_config[touch_decision_pkg::TOUCH_DEB_LSB +: 2],
				r.wheel_debounce_config[touch_decision_pkg::REL_DEB_LSB +: 2]);
		end
		else if (sec_hit)
			d = hold(st.whl, r.wheel_hold_timeout);
		else
			d = '{c: st.whl, touch: 1'b0, rel: 1'b0};
		next_st.whl = d.c;
		next_st.whl_touch_pulse = d.touch;
		next_st.whl_rel_pulse = d.rel;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '0;
			st.regs <= touch_decision_pkg::REGS_RST;
		end
		else
			st <= next_st;
	end

	always_comb
	begin
		for (int i = 0; i < N; i++)
			button_touched[i] = st.btn[i].touched;
	end

	assign reg_rdata = st.rdata;
	assign avg_suspend = st.avg_suspend;
	assign touch_pulse = st.touch_pulse;
	assign release_pulse = st.rel_pulse;
	assign irq = st.irq;
	assign comp_req = st.comp_req;
	assign wheel_touched = st.whl.touched;
	assign wheel_touch_pulse = st.whl_touch_pulse;
	assign wheel_release_pulse = st.whl_rel_pulse;
endmodule : touch_button_decision

// [tb/scan_front_end.sv]
// Purpose: Front end stand-in that hands one tick sample per scan
// Assumes: The bench asks for a scan with a one-cycle go
// Notes: Between scans the lines toggle so stale values never pass
`timescale 1ns/1ps
module scan_front_end #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic go,
	input wire logic [N-1:0][15:0] tk_in,
	input wire logic [15:0] pr_in,
	output logic sample_valid,
	output logic [N-1:0][15:0] ticks,
	output logic [N-1:0][15:0] sensor_touch_level,
	output logic [15:0] wheel_pressure
);
	logic g;
	initial
	begin
		sample_valid = 1'b0;
		ticks = '0;
		wheel_pressure = 16'h0000;
		sensor_touch_level = {N{16'h0064}};
	end
	// ----------------
	// One sample per scan
	// ----------------
	always @(posedge clk)
	begin
		g = go;
		#1 sample_valid = g;
		ticks = g ? tk_in : ~ticks;
		wheel_pressure = g ? pr_in : ~wheel_pressure;
	end
endmodule : scan_front_end

// [tb/touch_button_decision_checker.sv]
// Purpose: Port-level checks of the touch decision block
// Assumes: One clock, asynchronous active-low reset
// Notes: Config is internal, so checks tie outputs to each other
`timescale 1ns/1ps
module touch_button_decision_checker #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sample_valid,
	input wire logic [N-1:0] button_touched,
	input wire logic [N-1:0] avg_suspend,
	input wire logic touch_pulse,
	input wire logic release_pulse,
	input wire logic irq,
	input wire logic comp_req,
	input wire logic wheel_touched,
	input wire logic wheel_touch_pulse,
	input wire logic wheel_release_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ----------------
	// Sequences
	// ----------------
	sequence took_sample;
		$past(sample_valid);
	endsequence
	sequence wheel_rise;
		!wheel_touched ##1 wheel_touched;
	endsequence
	// ----------------
	// Assertions
	// ----------------
	touch_from_sample_a: assert property (touch_pulse |-> took_sample)
		else $error("touch pulse without a sample");
	touch_reported_a: assert property ((button_touched & ~$past(button_touched)) != '0 |->
		touch_pulse) else $error("new touch not pulsed");
	release_reported_a: assert property ((~button_touched & $past(button_touched)) != '0 |->
		release_pulse) else $error("release not pulsed");
	irq_source_a: assert property (irq |-> touch_pulse || release_pulse)
		else $error("irq without event");
	comp_source_a: assert property (comp_req |-> took_sample)
		else $error("compensation without a sample");
	avg_hold_a: assert property (!$past(sample_valid) |-> $stable(avg_suspend))
		else $error("average suspend moved between samples");
	wheel_touch_a: assert property (wheel_rise |-> wheel_touch_pulse)
		else $error("wheel touch not pulsed");
	wheel_release_a: assert property (wheel_release_pulse |-> !wheel_touched &&
		$past(wheel_touched)) else $error("wheel release pulse wrong");
endmodule : touch_button_decision_checker

bind touch_button_decision touch_button_decision_checker #(.N(N)) chk (
	.clk, .nrst, .sample_valid, .button_touched, .avg_suspend, .touch_pulse,
	.release_pulse, .irq, .comp_req, .wheel_touched, .wheel_touch_pulse,
	.wheel_release_pulse
);

// [tb/touch_button_decision_tb.sv]
// Purpose: Self-checking bench for the touch decision block
// Assumes: A second shortened to 20 cycles so hold timeouts fit
// Notes: Sensor levels are 100, so 10 percent gives 110 and 90
`timescale 1ns/1ps
module touch_button_decision_tb;
	localparam int N = 8;
	typedef struct packed {
		logic [15:0] t;
		logic [15:0] p;
		logic [5:0] e;
	} row_s;
	// Expect: touched0, touch, release, comp, avg0, wheel
	localparam row_s ROWS [8] = '{'{16'h006e, 16'h000c, 6'h00},
		'{16'h006f, 16'h000d, 6'h31}, '{16'h0140, 16'h000d, 6'h23},
		'{16'h005a, 16'h000d, 6'h21}, '{16'h0059, 16'h0000, 6'h08},
		'{16'hfec0, 16'h0000, 6'h00}, '{16'hfebf, 16'h0000, 6'h04},
		'{16'h0000, 16'h0000, 6'h00}};
	localparam logic [15:0] HY [4] = '{16'h0078, 16'h0079, 16'h0050, 16'h004f};
	logic clk;
	logic nrst = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic go = 1'b0;
	logic [N-1:0][15:0] tk_in = '0;
	logic [15:0] pr_in = 16'h0000;
	logic sample_valid;
	logic [N-1:0][15:0] ticks;
	logic [N-1:0][15:0] sensor_touch_level;
	logic [15:0] wheel_pressure;
	logic [N-1:0] button_touched;
	logic [N-1:0] avg_suspend;
	logic touch_pulse, release_pulse, irq, comp_req;
	logic wheel_touched, wheel_touch_pulse, wheel_release_pulse;
	logic [5:0] obs;
	int failures = 0;
	int samples_checked = 0;
	int n;
	assign obs = {button_touched[0], touch_pulse, release_pulse, comp_req, avg_suspend[0],
		wheel_touched};
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	scan_front_end #(.N(N)) fe (.clk, .go, .tk_in, .pr_in, .sample_valid, .ticks,
		.sensor_touch_level, .wheel_pressure);
	touch_button_decision #(.N(N), .TW(16), .SEC_CYCLES(20)) dut (.clk, .nrst, .reg_wr,
		.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .sample_valid, .ticks,
		.sensor_touch_level, .wheel_pressure, .button_touched, .avg_suspend, .touch_pulse,
		.release_pulse, .irq, .comp_req, .wheel_touched, .wheel_touch_pulse,
		.wheel_release_pulse);
	// ----------------
	// Shared tasks
	// ----------------
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e)
		begin
			failures++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1 reg_wr = 1'b0;
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		chk(16'(reg_rdata), 16'(e));
		@(posedge clk);
		#1;
	endtask : rdc
	// Model takes go on one edge, the block takes the sample on the next
	task automatic scan(input logic [N-1:0][15:0] t, input logic [15:0] p);
		tk_in = t;
		pr_in = p;
		go = 1'b1;
		@(posedge clk);
		#1 go = 1'b0;
		@(posedge clk);
		#1;
	endtask : scan
	function automatic logic [N-1:0][15:0] s0(input logic [15:0] v);
		return {{(N-1){16'h0000}}, v};
	endfunction : s0
	task automatic final_report();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	// ----------------
	// Sequence
	// ----------------
	initial
	begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		chk({button_touched, avg_suspend}, 16'h0000);
		for (int i = 0; i < 9; i++)
			rdc(8'h21 + 8'(i), touch_decision_pkg::REGS_RST[71 - 8 * i -: 8]);
		rdc(8'h20, 8'h00);
		wr(8'h27, 8'hff);
		rdc(8'h27, 8'h0f);
		wr(8'h27, 8'h00);
		foreach (ROWS[i])
		begin
			scan(s0(ROWS[i].t), ROWS[i].p);
			chk(16'(obs), 16'(ROWS[i].e));
			chk(16'(irq), 16'(ROWS[i].e[4] | ROWS[i].e[3]));
		end
		// Every debounce code, button and wheel together
		for (int k = 0; k < 4; k++)
		begin
			wr(8'h21, 8'h30 | 8'(k * 5));
			wr(8'h27, 8'(k * 5));
			repeat (k)
			begin
				scan(s0(16'h00c8), 16'h0020);
				chk(16'({obs[5], obs[0]}), 16'h0000);
			end
			scan(s0(16'h00c8), 16'h0020);
			chk(16'({obs[5], obs[0]}), 16'h0003);
			repeat (k)
			begin
				scan(s0(16'h0032), 16'h0000);
				chk(16'({obs[5], obs[0]}), 16'h0003);
			end
			scan(s0(16'h0032), 16'h0000);
			chk(16'({obs[5], obs[0]}), 16'h0000);
		end
		// Wheel back to single-sample decisions for the checks below
		wr(8'h27, 8'h00);
		for (int c = 0; c < 4; c++)
		begin
			wr(8'h21, 8'(c * 16));
			scan(s0(16'h00c8), 16'h0000);
			chk(16'(irq), 16'(c % 2));
			scan('0, 16'h0000);
			chk(16'(irq), 16'(c / 2));
		end
		wr(8'h21, 8'h70);
		scan(s0(16'h00c8), 16'h0000);
		scan({{(N-2){16'h0000}}, 16'h00c8, 16'h00c8}, 16'h0000);
		chk(16'({button_touched[1:0], touch_pulse}), 16'h0002);
		scan({{(N-2){16'h0000}}, 16'h00c8, 16'h0000}, 16'h0000);
		chk(16'({button_touched[0], release_pulse}), 16'h0001);
		scan('0, 16'h0000);
		wr(8'h21, 8'h30);
		scan({{(N-2){16'h0000}}, 16'h0190, 16'h0190}, 16'h0000);
		chk(16'({comp_req, avg_suspend[2:0]}), 16'h0003);
		scan({{(N-3){16'h0000}}, {3{16'h0190}}}, 16'h0000);
		chk(16'({comp_req, avg_suspend[2:0]}), 16'h000f);
		scan('0, 16'h0000);
		wr(8'h29, 8'h05);
		scan('0, 16'h0014);
		chk(16'(wheel_touched), 16'h0000);
		scan('0, 16'h0015);
		chk(16'(wheel_touched), 16'h0001);
		scan('0, 16'h0000);
		// Forced release after two seconds, then a real release re-arms
		wr(8'h26, 8'h02);
		scan(s0(16'h00c8), 16'h0000);
		n = 0;
		while (release_pulse !== 1'b1 && n < 60)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(16'(n >= 18 && n <= 42), 16'h0001);
		scan(s0(16'h00c8), 16'h0000);
		chk(16'(button_touched[0]), 16'h0000);
		scan(s0(16'h0032), 16'h0000);
		scan(s0(16'h00c8), 16'h0000);
		chk(16'(touch_pulse), 16'h0001);
		wr(8'h26, 8'h00);
		repeat (60) @(posedge clk);
		#1;
		chk(16'(button_touched[0]), 16'h0001);
		scan('0, 16'h0000);
		wr(8'h25, 8'h14);
		foreach (HY[i])
		begin
			scan(s0(HY[i]), 16'h0000);
			chk(16'(button_touched[0]), 16'(i == 1 || i == 2));
		end
		// Wheel forced release after one second
		wr(8'h28, 8'h01);
		scan('0, 16'h0020);
		n = 0;
		while (wheel_release_pulse !== 1'b1 && n < 30)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk(16'(n >= 1 && n <= 21), 16'h0001);
		chk(16'(wheel_touched), 16'h0000);
		scan(s0(16'h00c8), 16'h0000);
		nrst = 1'b0;
		#1 chk(16'(button_touched), 16'h0000);
		@(posedge clk);
		#1 nrst = 1'b1;
		rdc(8'h25, 8'h0a);
		final_report();
	end
	// Whole run is well under 20000 cycles
	initial
	begin
		#2000000;
		failures++;
		final_report();
	end
endmodule : touch_button_decision_tb
